// ---- rtl/tms_pkg.sv ----
// Package: constants, states and carriers for the transceiver mode sequencer
package tms_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPMODE    = 8'h00;
  localparam logic [7:0] ADDR_TIMING    = 8'h04;
  localparam logic [7:0] ADDR_LISTEN    = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_RXTIME    = 8'h10;

  // Operating mode register fields
  localparam int OPM_MODE_LSB   = 0;
  localparam int OPM_CANCEL_BIT = 5;
  localparam int OPM_LISTEN_BIT = 6;
  localparam int OPM_BYPASS_BIT = 7;
  localparam int OPM_OOK_BIT    = 8;
  localparam int OPM_PKT_BIT    = 9;
  localparam int OPM_BSYNC_BIT  = 10;
  localparam logic [10:0] OPM_RESET = 11'h001;

  // Mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY  = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX    = 3'h3;
  localparam logic [2:0] MODE_RX    = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int TX_FIXED_US      = 5;
  localparam int TX_FIXED_CYC     = TX_FIXED_US * CLK_MHZ;
  localparam int RX_FRONT_US      = 20;
  localparam int RX_FRONT_CYC     = RX_FRONT_US * CLK_MHZ;
  localparam int PLL_BW_KHZ       = 300;
  localparam int RELOCK_NUM       = 5;
  // 5 / 300 kHz = 16.67 us, rounded up
  localparam int RELOCK_CYC       = (RELOCK_NUM * CLK_MHZ * 1000 + PLL_BW_KHZ - 1) / PLL_BW_KHZ;
  localparam int FILT_NUM_FSK     = 21;
  localparam int FILT_NUM_OOK     = 34;
  localparam int DCC_MIN          = 8;
  localparam int RSSI_MULT        = 2;
  localparam int RAMP_NUM         = 5;  // 1.25 = 5/4
  localparam int RAMP_DEN         = 4;
  localparam int PREAMBLE_BITS    = 12;
  localparam int RES1_US          = 64;
  localparam int RES2_US          = 4100;
  localparam int RES3_US          = 262000;
  localparam int XO_WAKE_CYC_DEF  = 50;
  localparam int SYN_WAKE_CYC_DEF = 60;
  localparam int RC_DIV_CYC       = 100;  // one microsecond tick

  localparam logic [15:0] TIMING_RESET = 16'h0a0a;
  localparam logic [15:0] LISTEN_RESET = 16'h0101;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP  = 4'b0000,
    ST_XO     = 4'b0001,
    ST_STBY   = 4'b0010,
    ST_SYN    = 4'b0011,
    ST_SYNRDY = 4'b0100,
    ST_PAREG  = 4'b0101,
    ST_TXSU   = 4'b0110,
    ST_TX     = 4'b0111,
    ST_RXSU   = 4'b1000,
    ST_RX     = 4'b1001,
    ST_LIDLE  = 4'b1010,
    ST_LRX    = 4'b1011
  } tms_state_e;

  typedef struct packed {
    logic xo_on;
    logic synth_on;
    logic pa_reg_on;
    logic pa_ramp_on;
    logic tx_on;
    logic rx_on;
    logic rc_on;
  } tms_power_s;

  typedef struct packed {
    logic mode_reached;
    logic tx_ready;
    logic rx_ready;
    logic bit_clock_en;
    logic preamble_tx;
    logic packet_go;
    logic data_valid;
  } tms_event_s;

endpackage

// ---- rtl/tms_sequencer.sv ----
// Operating-mode sequencer with AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Summary of operation
// [RL1] Listen off: mode field decodes sleep, standby, synth, transmit, receive.
// [RL2] Each mode powers only its own blocks.
// [RL3] Listen entered from standby; mode field ignored while listen set.
// [RL4] Mode changes walk sub-blocks up in a fixed order.
// [RL5] Bypass bit applies requested mode directly, skipping wake steps.
// [RL6] Sleep to transmit: standby with crystal, synth, transmit after lock.
// [RL7] Transmit: PA regulator, then PA ramp, then bit clock.
// [RL8] PLL lock output high only inside lock range.
// [RL9] Tx startup 5 us plus 1.25 ramp plus half bit; no ramp in OOK.
// [RL10] Mode reached and transmit ready signalled when transmitter is ready.
// [RL11] Host may drive preamble after a transmit ready event.
// [RL12] Packet mode: auto preamble at ready, packet waits launch condition.
// [RL13] Rx startup 20 us plus 21 or 34 over four bandwidths.
// [RL14] RSSI interval: two times int(4 BW Tbit) over 4 BW.
// [RL15] DC settling: max(8, power of two) over 4 BW.
// [RL16] PLL relock after correction: 5 over 300 kHz.
// [RL17] Receiver ready raised when receive startup finishes.
// [RL18] Continuous without bit sync: data valid straight after receiver ready.
// [RL19] With bit sync, 12 preamble bits needed before data.
// [RL20] Host hops Tx channel through receive, then Tx start procedure.
// [RL21] Host hops Rx channel through synth, then Rx start procedure.
// [RL22] Listen idles on RC, wakes receiver, keeps it on wanted signal.
// [RL23] Listen windows: coefficient 1..255 times 64us, 4.1ms or 262ms.
// [RL24] Host stops listen with cancel set, then cancel cleared.
// [RL25] Mode reached only after every required sub-block woke.
// ------------------------------------------------------------------
module tms_sequencer
  import tms_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog status pins
  input  wire logic        pll_in_range,
  input  wire logic        signal_wanted,
  input  wire logic        launch_condition,
  input  wire logic        demod_bit,
  input  wire logic        bit_edge,
  // Sub-block controls and events
  output tms_power_s       power,
  output tms_event_s       events,
  output logic             pll_lock,
  output logic             serial_data_pin
);

  // ----------------------------------------------------------------
  // Pin synchronisers (three stages, change when 2nd and 3rd agree)
  // ----------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pin_q;
  wire  [4:0] pin_raw = {bit_edge, demod_bit, launch_condition, signal_wanted, pll_in_range};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      pin_q <= 5'h00;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= (sync2 & sync3) | (pin_q & (sync2 | sync3));
    end
  end

  wire lock_s  = pin_q[0];
  wire want_s  = pin_q[1];
  wire launch_s = pin_q[2];
  wire data_s  = pin_q[3];
  wire edge_s  = pin_q[4];
  logic edge_d;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [10:0] opmode;
  logic [15:0] timing;   // [7:0] pa ramp us, [15:8] bit period us
  logic [15:0] listen;   // [7:0] idle coef, [15:8] rx coef
  logic [3:0]  listen_res; // [1:0] idle res, [3:2] rx res
  logic [15:0] rx_bw_khz;
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;

  wire addr_phase = hsel & hready & htrans[1];
  wire wr_opmode  = ap_valid & ap_write & (ap_addr == ADDR_OPMODE);
  wire wr_timing  = ap_valid & ap_write & (ap_addr == ADDR_TIMING);
  wire wr_listen  = ap_valid & ap_write & (ap_addr == ADDR_LISTEN);
  wire wr_rxtime  = ap_valid & ap_write & (ap_addr == ADDR_RXTIME);

  wire [2:0] req_mode    = opmode[OPM_MODE_LSB +: 3];
  wire       listen_en   = opmode[OPM_LISTEN_BIT];
  wire       cancel      = opmode[OPM_CANCEL_BIT];
  wire       bypass      = opmode[OPM_BYPASS_BIT];
  wire       ook         = opmode[OPM_OOK_BIT];
  wire       pkt_mode    = opmode[OPM_PKT_BIT];
  wire       bsync       = opmode[OPM_BSYNC_BIT];
  wire [7:0] pa_ramp_us  = timing[7:0];
  wire [7:0] tbit_us     = timing[15:8];

  tms_state_e state;
  tms_state_e next_state;
  logic [31:0] status_word;
  logic [31:0] read_mux;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid   <= 1'b0;
      ap_write   <= 1'b0;
      ap_addr    <= 8'h00;
      opmode     <= OPM_RESET;
      timing     <= TIMING_RESET;
      listen     <= LISTEN_RESET;
      listen_res <= 4'h5;
      rx_bw_khz  <= 16'h000a;
      hrdata     <= 32'h0000_0000;
    end
    else
    begin
      ap_valid <= addr_phase;
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
      hrdata   <= (addr_phase & ~hwrite) ? read_mux : 32'h0000_0000;
      if (wr_opmode)
        opmode <= hwdata[10:0];
      if (wr_timing)
        timing <= hwdata[15:0];
      if (wr_listen)
      begin
        listen     <= hwdata[15:0];
        listen_res <= hwdata[19:16];
      end
      if (wr_rxtime)
        rx_bw_khz <= hwdata[15:0];
    end
  end

  // Reads are taken in the address phase so data is ready with zero wait
  always_comb
  begin
    case (haddr[7:0])
      ADDR_OPMODE: read_mux = {21'h0, opmode};
      ADDR_TIMING: read_mux = {16'h0, timing};
      ADDR_LISTEN: read_mux = {12'h0, listen_res, listen};
      ADDR_STATUS: read_mux = status_word;
      ADDR_RXTIME: read_mux = {16'h0, rx_bw_khz};
      default:     read_mux = 32'h0000_0000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Startup delays
  // ----------------------------------------------------------------
  // Tx: 5 us + 1.25 ramp + Tbit/2; ramp dropped in OOK
  wire [31:0] ramp_cyc  = ook ? 32'h0 : ((32'(pa_ramp_us) * RAMP_NUM * CLK_MHZ) / RAMP_DEN);  // RL9
  wire [31:0] tx_su_cyc = TX_FIXED_CYC + ramp_cyc + (32'(tbit_us) * CLK_MHZ) / 2;            // RL9
  // Rx: 20 us + filter delay num / (4 BW); BW in kHz
  wire [31:0] bw4       = (rx_bw_khz == 16'h0) ? 32'h4 : 32'(rx_bw_khz) * 4;
  wire [31:0] filt_num  = ook ? FILT_NUM_OOK : FILT_NUM_FSK;                                  // RL13
  wire [31:0] rx_su_cyc = RX_FRONT_CYC + (filt_num * CLK_MHZ * 1000) / bw4;                   // RL13
  // RSSI interval: 2 * int(4 BW Tbit) / (4 BW)
  wire [31:0] bwt4      = (bw4 * 32'(tbit_us)) / 1000;
  wire [31:0] rssi_cyc  = (RSSI_MULT * bwt4 * CLK_MHZ * 1000) / bw4;                          // RL14
  // DC settling: max(8, 2^round(log2(8 BW Tbit)+1)) / (4 BW)
  logic [31:0] dcc_pow;
  always_comb
  begin
    dcc_pow = 32'h1;
    for (int i = 0; i < 20; i++)
      if ((64'(bwt4) * 64'(bwt4) * 64'h8) >= (64'h1 << (2 * i)))
        dcc_pow = 32'h2 << i;
  end
  wire [31:0] dcc_num   = (dcc_pow > DCC_MIN) ? dcc_pow : DCC_MIN;                            // RL15
  wire [31:0] dcc_cyc   = (dcc_num * CLK_MHZ * 1000) / bw4;                                   // RL15
  wire [31:0] rx_total  = rx_su_cyc + dcc_cyc + rssi_cyc + RELOCK_CYC;                        // RL16

  // ----------------------------------------------------------------
  // Listen window timer on RC tick
  // ----------------------------------------------------------------
  logic [6:0]  rc_div;
  wire         rc_tick = (rc_div == 7'(RC_DIV_CYC - 1));
  function automatic logic [31:0] res_us(input logic [1:0] r);
    case (r)
      2'h1:    res_us = RES1_US;
      2'h2:    res_us = RES2_US;
      2'h3:    res_us = RES3_US;
      default: res_us = RES1_US;
    endcase
  endfunction
  wire [7:0]  idle_coef = (listen[7:0] == 8'h0) ? 8'h1 : listen[7:0];
  wire [7:0]  rx_coef   = (listen[15:8] == 8'h0) ? 8'h1 : listen[15:8];
  wire [31:0] idle_us   = 32'(idle_coef) * res_us(listen_res[1:0]);                           // RL23
  wire [31:0] lrx_us    = 32'(rx_coef) * res_us(listen_res[3:2]);                             // RL23

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] cnt;
  logic [4:0]  pre_bits;
  logic        listen_armed;
  wire         in_listen = listen_en & listen_armed & ~cancel;                                // RL3
  wire         wait_done = (cnt == 32'h0);
  wire         cnt_load  = (next_state != state);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_SLEEP:  if (in_listen || req_mode != MODE_SLEEP)
                   next_state = bypass ? ST_STBY : ST_XO;                                     // RL6
      ST_XO:     if (wait_done) next_state = ST_STBY;                                         // RL4
      ST_STBY:   if (in_listen) next_state = ST_LIDLE;                                        // RL22
                 else if (req_mode == MODE_SLEEP) next_state = ST_SLEEP;
                 else if (req_mode >= MODE_SYNTH && req_mode <= MODE_RX) // RL1
                   next_state = bypass ? ST_SYNRDY : ST_SYN;
      ST_SYN:    if (lock_s && wait_done) next_state = ST_SYNRDY;                             // RL6
      ST_SYNRDY: if (req_mode == MODE_TX) next_state = bypass ? ST_TX : ST_PAREG;             // RL5
                 else if (req_mode == MODE_RX) next_state = bypass ? ST_RX : ST_RXSU;
                 else if (req_mode != MODE_SYNTH) next_state = ST_STBY;
      ST_PAREG:  if (wait_done) next_state = ST_TXSU;                                         // RL7
      ST_TXSU:   if (wait_done) next_state = ST_TX;                                           // RL9
      ST_TX:     if (req_mode != MODE_TX) next_state = ST_SYNRDY;
      ST_RXSU:   if (wait_done) next_state = ST_RX;                                           // RL17
      ST_RX:     if (req_mode != MODE_RX) next_state = ST_SYNRDY;
      ST_LIDLE:  if (!in_listen) next_state = ST_STBY;
                 else if (wait_done) next_state = ST_LRX;                                     // RL22
      ST_LRX:    if (!in_listen) next_state = ST_STBY;
                 else if (wait_done && !want_s) next_state = ST_LIDLE;                        // RL22
      default:   next_state = ST_SLEEP;
    endcase
    if ((state != ST_LIDLE) && (state != ST_LRX) && in_listen && (state != ST_STBY)
        && (state != ST_SLEEP))
      next_state = ST_STBY;
  end

  logic [31:0] next_cnt;
  always_comb
  begin
    case (next_state)
      ST_XO:    next_cnt = XO_WAKE_CYC_DEF;
      ST_SYN:   next_cnt = SYN_WAKE_CYC_DEF;
      ST_PAREG: next_cnt = 32'h1;
      ST_TXSU:  next_cnt = tx_su_cyc;
      ST_RXSU:  next_cnt = rx_total;
      ST_LIDLE: next_cnt = idle_us;
      ST_LRX:   next_cnt = lrx_us + rx_total / CLK_MHZ;
      default:  next_cnt = 32'h0;
    endcase
  end

  // Listen windows count RC microsecond ticks, others count clock cycles
  wire listen_state = (state == ST_LIDLE) || (state == ST_LRX);
  wire cnt_step     = listen_state ? rc_tick : 1'b1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state        <= ST_STBY;
      cnt          <= 32'h0;
      rc_div       <= 7'h0;
      listen_armed <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      rc_div <= rc_tick ? 7'h0 : rc_div + 7'h1;
      if (cnt_load)
        cnt <= next_cnt;
      else if (!wait_done && cnt_step)
        cnt <= cnt - 32'h1;
      // Listen may only arm while sitting in standby or in a listen window
      if (!listen_en || cancel)
        listen_armed <= 1'b0;
      else if (state == ST_STBY || listen_state)
        listen_armed <= 1'b1;                                                                 // RL3
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire tx_full = (state == ST_TX);
  wire rx_full = (state == ST_RX) || (state == ST_LRX && want_s);
  logic next_valid;
  assign next_valid = rx_full && (!(pkt_mode || bsync) || pre_bits >= 5'(PREAMBLE_BITS));     // RL19

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power           <= '0;
      events          <= '0;
      pll_lock        <= 1'b0;
      serial_data_pin <= 1'b0;
      pre_bits        <= 5'h0;
      edge_d          <= 1'b0;
    end
    else
    begin
      edge_d <= edge_s;
      if (!rx_full)
        pre_bits <= 5'h0;
      else if (edge_s && !edge_d && pre_bits < 5'(PREAMBLE_BITS))
        pre_bits <= pre_bits + 5'h1;                                                          // RL19
      power.xo_on      <= (state != ST_SLEEP) && !listen_state;                               // RL2
      power.synth_on   <= (state == ST_SYN) || (state == ST_SYNRDY) || (state == ST_PAREG)
                          || (state == ST_TXSU) || tx_full || (state == ST_RXSU)
                          || (state == ST_RX) || (state == ST_LRX);                            // RL2
      power.pa_reg_on  <= (state == ST_PAREG) || (state == ST_TXSU) || tx_full;               // RL7
      power.pa_ramp_on <= (state == ST_TXSU) || tx_full;                                      // RL7
      power.tx_on      <= (state == ST_TXSU) || tx_full;                                      // RL2
      power.rx_on      <= (state == ST_RXSU) || (state == ST_RX) || (state == ST_LRX);        // RL22
      power.rc_on      <= listen_state;                                                       // RL22
      pll_lock         <= lock_s;                                                             // RL8
      events.mode_reached <= (state == ST_SLEEP && req_mode == MODE_SLEEP)
                          || (state == ST_STBY && req_mode == MODE_STBY && !in_listen)
                          || (state == ST_SYNRDY && req_mode == MODE_SYNTH)
                          || (tx_full && req_mode == MODE_TX)
                          || ((state == ST_RX) && req_mode == MODE_RX)
                          || listen_state;                                                    // RL25
      events.tx_ready     <= tx_full;                                                         // RL10
      events.rx_ready     <= (state == ST_RX) || (state == ST_LRX);                           // RL17
      events.bit_clock_en <= tx_full;                                                         // RL7
      events.preamble_tx  <= tx_full && pkt_mode;                                             // RL12
      events.packet_go    <= tx_full && pkt_mode && launch_s;                                 // RL12
      events.data_valid   <= next_valid;                                                      // RL18
      serial_data_pin     <= next_valid ? data_s : 1'b0;                                      // RL18
    end
  end

  assign status_word = {16'h0, 2'h0, pre_bits[4:0], events.rx_ready, events.tx_ready,
                        events.mode_reached, pll_lock, 1'b0, state};

endmodule

// ---- verification/tms_sequencer_properties.sv ----
// Checker: port-level properties of the mode sequencer
`timescale 1ns/1ps
module tms_sequencer_checker
  import tms_pkg::*;
(
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus response
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Pins and controls
  input wire logic       pll_in_range,
  input wire tms_power_s power,
  input wire tms_event_s events,
  input wire logic       pll_lock,
  input wire logic       serial_data_pin
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_bus_always_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_lock_follows_range: assert property ($rose(pll_in_range) |-> ##[1:6] pll_lock)
    else $error("lock output did not follow range");
  a_lock_drops_out: assert property ($fell(pll_in_range) |-> ##[1:6] !pll_lock)
    else $error("lock output stayed high");
  a_tx_ready_powered: assert property (events.tx_ready |-> power.tx_on && power.synth_on)
    else $error("transmit ready without transmit power");
  a_ramp_after_reg: assert property (power.pa_ramp_on |-> power.pa_reg_on)
    else $error("PA ramp without PA regulator");
  a_bitclk_after_ramp: assert property (events.bit_clock_en |-> power.pa_ramp_on)
    else $error("bit clock before PA ramp");
  a_tx_with_mode: assert property ($rose(events.tx_ready) |-> events.mode_reached)
    else $error("transmit ready without mode reached");
  a_rx_ready_powered: assert property (events.rx_ready |-> power.rx_on && !power.tx_on)
    else $error("receive ready with wrong power");
  a_serial_quiet: assert property (!events.data_valid [*2] |-> !serial_data_pin)
    else $error("serial data driven while not valid");
endmodule

bind tms_sequencer tms_sequencer_checker u_tms_sequencer_checker (
  .hclk           (hclk),
  .hresetn        (hresetn),
  .hreadyout      (hreadyout),
  .hresp          (hresp),
  .pll_in_range   (pll_in_range),
  .power          (power),
  .events         (events),
  .pll_lock       (pll_lock),
  .serial_data_pin(serial_data_pin)
);

// ---- verification/tms_analog_model.sv ----
// Partner model: synthesizer lock, demodulator and launch pins
`timescale 1ns/1ps
module tms_analog_model
  import tms_pkg::*;
#(
  parameter int LOCK_CYC = 200
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Controls from the sequencer and bench
  input  wire tms_power_s power,
  input  wire logic       want,
  input  wire logic       launch,
  // Pins towards the sequencer
  output logic            pll_in_range,
  output logic            signal_wanted,
  output logic            launch_condition,
  output logic            demod_bit,
  output logic            bit_edge
);
  int         lock_cnt;
  logic [4:0] div;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_cnt     <= 0;
      div          <= 5'h00;
      pll_in_range <= 1'b0;
    end
    else
    begin
      div          <= div + 5'h01;
      lock_cnt     <= !power.synth_on ? 0 : (lock_cnt < LOCK_CYC ? lock_cnt + 1 : lock_cnt);
      pll_in_range <= power.synth_on && lock_cnt == LOCK_CYC;
    end
  end

  // Alternating preamble, one bit per 16 cycles, one edge pulse per 32 cycles; edge pulse wide enough to pass the pin filter
  assign bit_edge         = (div[4:3] == 2'b00);
  assign demod_bit        = div[4];
  assign signal_wanted    = want && power.rx_on;
  assign launch_condition = launch && power.tx_on;
endmodule

// ---- verification/tb_tms_sequencer.sv ----
// Testbench: register-driven scenarios for the mode sequencer
`timescale 1ns/1ps
module tb_tms_sequencer
  import tms_pkg::*;
;
  localparam int TXF = TX_FIXED_CYC + RAMP_NUM * 10 * CLK_MHZ / RAMP_DEN + 10 * CLK_MHZ / 2;
  localparam int TXO = TX_FIXED_CYC + 10 * CLK_MHZ / 2;
  // Rx at 500 kHz, 10 us bit: DC settling 64, RSSI 2 x 20
  localparam int RXE = RX_FRONT_CYC + (FILT_NUM_FSK + 64 + RSSI_MULT * 20) * CLK_MHZ / 2 + RELOCK_CYC;

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, want = 1'b0, launch = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hready, hreadyout, hresp, pll_in_range, signal_wanted, launch_condition;
  logic        demod_bit, bit_edge, pll_lock, serial_data_pin;
  logic [9:0]  mon;
  tms_power_s  power;
  tms_event_s  events;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, t0 = 0;

  always #5 hclk = ~hclk;
  always @(posedge hclk) cyc++;
  assign hready = hreadyout;
  assign mon    = {events.packet_go, events.data_valid, events.rx_ready, events.tx_ready, pll_lock,
                   power.rc_on, power.rx_on, power.tx_on, power.synth_on, power.xo_on};

  tms_sequencer u_tms_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pll_in_range(pll_in_range), .signal_wanted(signal_wanted),
    .launch_condition(launch_condition), .demod_bit(demod_bit), .bit_edge(bit_edge), .power(power),
    .events(events), .pll_lock(pll_lock), .serial_data_pin(serial_data_pin));

  tms_analog_model u_tms_analog_model (.clk(hclk), .rst_n(hresetn), .power(power), .want(want),
    .launch(launch), .pll_in_range(pll_in_range), .signal_wanted(signal_wanted),
    .launch_condition(launch_condition), .demod_bit(demod_bit), .bit_edge(bit_edge));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic go(input logic [31:0] m);
    ahb(1'b1, ADDR_OPMODE, m);
    t0 = cyc;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Bounded wait for one monitored output, sampled after the edge settles
  task automatic wt(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (mon[i] !== v && k < lim)
    begin
      @(posedge hclk);
      #1;
      k++;
    end
    chk(32'(mon[i]), 32'(v));
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ADDR_OPMODE, 32'h0); chk(rd, {21'h0, OPM_RESET});
    ahb(1'b0, ADDR_TIMING, 32'h0); chk(rd, {16'h0, TIMING_RESET});
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    $display("test registers done");
    go(32'h0); wt(0, 1'b0, 100); chk(32'(power), 32'h0);
    go(32'h203); wt(1, 1'b1, 300); chk({30'h0, power.xo_on, power.tx_on}, 32'h2);
    wt(2, 1'b1, 800); chk(32'(pll_lock), 32'h1);
    chk({29'h0, power.pa_reg_on, power.pa_ramp_on, events.bit_clock_en}, 32'h6);
    wt(6, 1'b1, 4000); chk(32'(cyc - t0 >= TXF && cyc - t0 <= TXF + 800), 32'h1);
    chk({29'h0, events.mode_reached, events.preamble_tx, events.packet_go}, 32'h6);
    launch <= 1'b1;
    wt(9, 1'b1, 20);
    ahb(1'b0, ADDR_STATUS, 32'h0); chk({31'h0, rd[7]}, 32'h1);
    launch <= 1'b0;
    go(32'h001); wt(2, 1'b0, 50);
    go(32'h103); wt(6, 1'b1, 4000); chk(32'(cyc - t0 >= TXO && cyc - t0 <= TXO + 800), 32'h1);
    $display("test transmit done");
    ahb(1'b1, ADDR_RXTIME, 32'd500);
    go(32'h004); wt(7, 1'b1, 40000); chk(32'(cyc - t0 >= RXE && cyc - t0 <= RXE + 20), 32'h1);
    chk(32'(power.tx_on), 32'h0);
    wt(8, 1'b1, 4);
    #1; rd[0] = serial_data_pin;
    repeat (16) @(posedge hclk);
    #1; chk(32'(rd[0] ^ serial_data_pin), 32'h1);
    go(32'h002); wt(3, 1'b0, 50); chk(32'(power.synth_on), 32'h1);
    go(32'h404); wt(7, 1'b1, 40000); chk(32'(events.data_valid), 32'h0);
    t0 = cyc;
    wt(8, 1'b1, 1000); chk(32'(cyc - t0 >= 11 * 32), 32'h1);
    $display("test receive done");
    go(32'h001); wt(3, 1'b0, 50);
    go(32'h083); wt(2, 1'b1, 10);
    go(32'h001); wt(2, 1'b0, 50);
    go(32'h005);
    repeat (20) @(posedge hclk);
    #1;
    chk({29'h0, power.xo_on, power.tx_on, power.rx_on}, 32'h4);
    $display("test bypass and undefined done");
    go(32'h001);
    ahb(1'b1, ADDR_LISTEN, 32'h0005_0101);
    go(32'h041); wt(4, 1'b1, 50); chk(32'(power.xo_on), 32'h0);
    ahb(1'b1, ADDR_OPMODE, 32'h043);
    t0 = cyc;
    wt(3, 1'b1, 7000); chk(32'(cyc - t0 >= RES1_US * CLK_MHZ - 300 && !power.tx_on), 32'h1);
    go(32'h021);
    go(32'h001); wt(4, 1'b0, 50); chk(32'(power.xo_on), 32'h1);
    $display("test listen done");
    end_sim();
  end

  initial
  begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule
